// ### hw/pmr_defs.svh
// Offsets, field positions, widths and reset values of the macrocell register array.
// Assumes nothing of its surroundings; included by the package, the top-level design file and the bench.
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

`define PMR_NUM_FF        20
`define PMR_NUM_PIN       10
`define PMR_ADDR_W        8
`define PMR_DATA_W        32

`define PMR_OFS_TYPE      8'h00
`define PMR_OFS_CLKSEL    8'h04
`define PMR_OFS_SECURE    8'h08
`define PMR_OFS_STATE     8'h0C
`define PMR_OFS_PINS      8'h10

`define PMR_SECURE_LOCK   0
`define PMR_SECURE_ERASE  1

`define PMR_CFG_RESET     20'h00000
`define PMR_FUSE_ALL      20'hFFFFF
`define PMR_SECURE_SHOWN  2'h1

`endif

// ### hw/pmr_pkg.sv
// Types shared by the macrocell register array and its flip-flop cell.
// Assumes the constants header is on the include path.
`include "pmr_defs.svh"

package pmr_pkg;

  typedef enum logic {PMR_FF_D, PMR_FF_T} pmr_ff_kind_t;

  typedef enum logic {PMR_CLK_TERM, PMR_CLK_PIN} pmr_clk_src_t;

  typedef logic [`PMR_NUM_FF-1:0]  pmr_ff_vec_t;
  typedef logic [`PMR_NUM_PIN-1:0] pmr_pin_vec_t;

endpackage

// ### hw/pmr_cell.sv
// One flip-flop of the array, modelled as a master and a slave stage sampled on pclk.
// Assumes all term inputs are already synchronised to pclk by the instantiating module.
`timescale 1ns/1ps

module pmr_cell (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire pmr_pkg::pmr_ff_kind_t kind,
  input  wire pmr_pkg::pmr_clk_src_t clk_src,
  input  wire logic                  sum,
  input  wire logic                  pt_clk,
  input  wire logic                  pin_clk,
  input  wire logic                  rst_term,
  input  wire logic                  preset,
  output logic                       q
);

  logic clk_now;
  logic rise;
  logic clk_lvl_q;
  logic clk_lvl_d;
  logic master_q;
  logic master_d;
  logic slave_q;
  logic slave_d;

  // The master follows its input while the chosen clock is low and the slave takes it on the rising edge.
  always_comb begin
    clk_now   = (clk_src == pmr_pkg::PMR_CLK_PIN) ? pin_clk : pt_clk;
    rise      = clk_now & ~clk_lvl_q;
    clk_lvl_d = clk_now;
    master_d  = master_q;
    slave_d   = slave_q;
    if (rst_term) begin
      master_d = 1'b0;
      slave_d  = 1'b0;
    end else begin
      if (rise) begin
        slave_d = master_q;
      end
      if (!clk_now) begin
        if (preset) begin
          master_d = 1'b1;
        end else if (kind == pmr_pkg::PMR_FF_T) begin
          master_d = slave_q ^ sum;
        end else begin
          master_d = sum;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_lvl_q <= 1'b0;
      master_q  <= 1'b0;
      slave_q   <= 1'b0;
    end else begin
      clk_lvl_q <= clk_lvl_d;
      master_q  <= master_d;
      slave_q   <= slave_d;
    end
  end

  assign q = slave_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_reset_clears_both: assert property (rst_term |=> (!master_q && !slave_q))
    else $error("Reset term did not clear master and slave.");
  a_edge_moves_slave: assert property ((rise && !rst_term) |=> (q == $past(master_q)))
    else $error("Slave did not take the master on a clock edge.");
  a_hold_no_edge: assert property ((!rise && !rst_term) |=> $stable(q))
    else $error("Register changed without a clock edge.");
  a_toggle_inverts: assert property (
    (!clk_now && !rst_term && !preset && kind == pmr_pkg::PMR_FF_T && sum)
    |=> (master_q != $past(slave_q)))
    else $error("Toggle register did not prepare an inverted state.");
  a_dtype_captures: assert property (
    (!clk_now && !rst_term && !preset && kind == pmr_pkg::PMR_FF_D)
    |=> (master_q == $past(sum)))
    else $error("Data register did not capture its sum term.");
  a_preset_sets: assert property ((!clk_now && preset && !rst_term) ##1 (rise && !rst_term) |=> q)
    else $error("Preset did not set the register on the next edge.");

  c_toggle_edge: cover property (rise && kind == pmr_pkg::PMR_FF_T && !rst_term);
  c_pin_clock: cover property (rise && clk_src == pmr_pkg::PMR_CLK_PIN);

endmodule

// ### hw/pmr_top.sv
// Register layer of a programmable logic device: twenty flip-flops, two per output cell.
// Assumes the product-term array and the pins are outside, asynchronous to pclk, and an APB master.
`timescale 1ns/1ps
`include "pmr_defs.svh"

module pmr_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [`PMR_ADDR_W-1:0]       paddr,
  input  wire logic [`PMR_DATA_W-1:0]       pwdata,
  output logic      [`PMR_DATA_W-1:0]       prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [`PMR_NUM_FF-1:0]       sum_term,
  input  wire logic [`PMR_NUM_FF-1:0]       clk_term,
  input  wire logic [`PMR_NUM_FF-1:0]       rst_term,
  input  wire logic                         sync_preset,
  input  wire logic                         pin_clk,
  input  wire logic [`PMR_NUM_PIN-1:0]      oe_term,
  input  wire logic [`PMR_NUM_PIN-1:0]      pin_in,
  output logic      [`PMR_NUM_PIN-1:0]      pin_out,
  output logic      [`PMR_NUM_PIN-1:0]      pin_oe_n,
  output logic      [`PMR_NUM_PIN-1:0]      pin_path,
  output logic      [`PMR_NUM_FF-1:0]       feedback
);

  localparam int SYNC_W = 3 * `PMR_NUM_FF + 2 + 2 * `PMR_NUM_PIN;

  // Every term comes from the array or a pin and is foreign to pclk, so all pass two flip-flops.
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {sum_term, clk_term, rst_term, sync_preset, pin_clk, oe_term, pin_in};
      sync2_q <= sync1_q;
    end
  end

  pmr_pkg::pmr_ff_vec_t  sum_s;
  pmr_pkg::pmr_ff_vec_t  clk_s;
  pmr_pkg::pmr_ff_vec_t  rst_s;
  logic                  preset_s;
  logic                  pin_clk_s;
  pmr_pkg::pmr_pin_vec_t oe_s;
  pmr_pkg::pmr_pin_vec_t pin_s;

  assign {sum_s, clk_s, rst_s, preset_s, pin_clk_s, oe_s, pin_s} = sync2_q;

  // Configuration: flip-flop type, clock source and the security fuse.
  pmr_pkg::pmr_ff_vec_t type_q;
  pmr_pkg::pmr_ff_vec_t type_d;
  pmr_pkg::pmr_ff_vec_t clksel_q;
  pmr_pkg::pmr_ff_vec_t clksel_d;
  logic                 secure_q;
  logic                 secure_d;

  logic                 setup_ph;
  logic                 wr_en;
  logic                 hit;
  logic [`PMR_DATA_W-1:0] rd_val;
  logic [`PMR_DATA_W-1:0] prdata_q;
  logic [`PMR_DATA_W-1:0] prdata_d;

  // The slave never stalls; read data is prepared in the setup cycle so prdata leaves a flip-flop.
  assign pready   = 1'b1;
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      `PMR_OFS_TYPE,
      `PMR_OFS_CLKSEL,
      `PMR_OFS_SECURE,
      `PMR_OFS_STATE,
      `PMR_OFS_PINS: hit = 1'b1;
      default:       hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~hit;

  // Verify reads of a secured part show every configuration fuse as programmed.
  always_comb begin
    rd_val = '0;
    unique case (paddr)
      `PMR_OFS_TYPE: begin
        rd_val[`PMR_NUM_FF-1:0] = secure_q ? `PMR_FUSE_ALL : type_q;
      end
      `PMR_OFS_CLKSEL: begin
        rd_val[`PMR_NUM_FF-1:0] = secure_q ? `PMR_FUSE_ALL : clksel_q;
      end
      `PMR_OFS_SECURE: begin
        rd_val[1:0] = secure_q ? `PMR_SECURE_SHOWN : 2'h0;
      end
      `PMR_OFS_STATE: begin
        rd_val[`PMR_NUM_FF-1:0] = feedback;
      end
      `PMR_OFS_PINS: begin
        rd_val[`PMR_NUM_PIN-1:0] = pin_path;
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  always_comb begin
    type_d   = type_q;
    clksel_d = clksel_q;
    secure_d = secure_q;
    prdata_d = prdata_q;
    if (setup_ph && !pwrite) begin
      prdata_d = rd_val;
    end
    if (wr_en) begin
      unique case (paddr)
        `PMR_OFS_TYPE: begin
          type_d = pwdata[`PMR_NUM_FF-1:0];
        end
        `PMR_OFS_CLKSEL: begin
          clksel_d = pwdata[`PMR_NUM_FF-1:0];
        end
        `PMR_OFS_SECURE: begin
          // Besides presetn, erase is the only way back from a secured part and wipes the pattern with it.
          if (pwdata[`PMR_SECURE_ERASE]) begin
            type_d   = `PMR_CFG_RESET;
            clksel_d = `PMR_CFG_RESET;
            secure_d = 1'b0;
          end else if (pwdata[`PMR_SECURE_LOCK]) begin
            secure_d = 1'b1;
          end
        end
        default: begin
          secure_d = secure_q;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_q   <= `PMR_CFG_RESET;
      clksel_q <= `PMR_CFG_RESET;
      secure_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      type_q   <= type_d;
      clksel_q <= clksel_d;
      secure_q <= secure_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

  // Twenty cells, two per output cell; the even one of each pair drives the pin.
  for (genvar i = 0; i < `PMR_NUM_FF; i++) begin : g_ff
    pmr_cell u_cell (
      .pclk    (pclk),
      .presetn (presetn),
      .kind    (pmr_pkg::pmr_ff_kind_t'(type_q[i])),
      .clk_src (pmr_pkg::pmr_clk_src_t'(clksel_q[i])),
      .sum     (sum_s[i]),
      .pt_clk  (clk_s[i]),
      .pin_clk (pin_clk_s),
      .rst_term(rst_s[i]),
      .preset  (preset_s),
      .q       (feedback[i])
    );
  end

  // Pin side: registered enable, registered dedicated input path.
  pmr_pkg::pmr_pin_vec_t oe_n_q;
  pmr_pkg::pmr_pin_vec_t oe_n_d;
  pmr_pkg::pmr_pin_vec_t path_q;
  pmr_pkg::pmr_pin_vec_t path_d;

  always_comb begin
    oe_n_d = ~oe_s;
    path_d = pin_s;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_q <= '1;
      path_q <= '0;
    end else begin
      oe_n_q <= oe_n_d;
      path_q <= path_d;
    end
  end

  for (genvar p = 0; p < `PMR_NUM_PIN; p++) begin : g_pin
    assign pin_out[p] = feedback[2*p];
  end

  assign pin_oe_n = oe_n_q;
  assign pin_path = path_q;

  // Edges since reset release, saturating at three. Checks that look three edges back wait for it,
  // because the first samples after release still carry the reset values of the synchronisers.
  logic [1:0] up_cnt_q;
  logic [1:0] up_cnt_d;

  always_comb begin
    up_cnt_d = up_cnt_q;
    if (up_cnt_q != 2'h3) begin
      up_cnt_d = up_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt_q <= 2'h0;
    end else begin
      up_cnt_q <= up_cnt_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_secure_hides_type: assert property (
    (setup_ph && !pwrite && paddr == `PMR_OFS_TYPE && secure_q)
    |=> (prdata[`PMR_NUM_FF-1:0] == `PMR_FUSE_ALL))
    else $error("Secured part revealed the type pattern.");
  a_secure_hides_clksel: assert property (
    (setup_ph && !pwrite && paddr == `PMR_OFS_CLKSEL && secure_q)
    |=> (prdata[`PMR_NUM_FF-1:0] == `PMR_FUSE_ALL))
    else $error("Secured part revealed the clock selection.");
  a_open_shows_type: assert property (
    (setup_ph && !pwrite && paddr == `PMR_OFS_TYPE && !secure_q)
    |=> (prdata[`PMR_NUM_FF-1:0] == $past(type_q)))
    else $error("Type readback does not match the configuration.");
  a_type_write_lands: assert property (
    (wr_en && paddr == `PMR_OFS_TYPE)
    |=> (type_q == $past(pwdata[`PMR_NUM_FF-1:0])))
    else $error("Type write did not land.");
  a_clksel_write_lands: assert property (
    (wr_en && paddr == `PMR_OFS_CLKSEL)
    |=> (clksel_q == $past(pwdata[`PMR_NUM_FF-1:0])))
    else $error("Clock selection write did not land.");
  a_secure_sticky: assert property (
    (secure_q && !(wr_en && paddr == `PMR_OFS_SECURE && pwdata[`PMR_SECURE_ERASE]))
    |=> secure_q)
    else $error("Security fuse cleared without erase.");
  a_lock_takes: assert property (
    (wr_en && paddr == `PMR_OFS_SECURE && pwdata[`PMR_SECURE_LOCK] && !pwdata[`PMR_SECURE_ERASE])
    |=> secure_q)
    else $error("Lock write did not secure the part.");
  a_erase_wipes: assert property (
    (wr_en && paddr == `PMR_OFS_SECURE && pwdata[`PMR_SECURE_ERASE])
    |=> (!secure_q && type_q == `PMR_CFG_RESET && clksel_q == `PMR_CFG_RESET))
    else $error("Erase left a pattern or the lock behind.");
  a_state_shows_fb: assert property (
    (setup_ph && !pwrite && paddr == `PMR_OFS_STATE)
    |=> (prdata[`PMR_NUM_FF-1:0] == $past(feedback)))
    else $error("State readback does not match the registers.");
  a_pin_path_delay: assert property ((up_cnt_q == 2'h3) |-> (pin_path == $past(pin_in, 3)))
    else $error("Dedicated input path lost the pin value.");
  a_oe_follows_term: assert property ((up_cnt_q == 2'h3) |-> (pin_oe_n == ~$past(oe_term, 3)))
    else $error("Pin enable does not follow its own term.");
  a_reset_clears_ff: assert property (##3 (rst_s[0] |=> !feedback[0]))
    else $error("Reset term did not clear the register.");
  // Every register must take the preset when all clocks rise together, whatever its clock source.
  a_preset_sets_all: assert property (
    (preset_s && rst_s == '0 && clk_s == '0 && !pin_clk_s) ##1 (clk_s == '1 && pin_clk_s && rst_s == '0)
    |=> (feedback == `PMR_FUSE_ALL))
    else $error("Preset did not set every register.");
  // The error checks decode the map from alignment and range, independently of the decoder above.
  a_unmapped_error: assert property ((psel && penable && (paddr[1:0] != 2'h0 || paddr > `PMR_OFS_PINS)) |-> pslverr)
    else $error("Unmapped address answered without error.");
  a_mapped_no_error: assert property ((psel && penable && paddr[1:0] == 2'h0 && paddr <= `PMR_OFS_PINS) |-> !pslverr)
    else $error("Mapped address answered with an error.");

  c_secure_read: cover property (setup_ph && !pwrite && secure_q ##1 psel && penable);
  c_preset_all: cover property (preset_s ##[1:20] (feedback == `PMR_FUSE_ALL));

endmodule

// ### sim/pmr_far_side.sv
// Far-side model: product-term clocks, the shared preset and the ten I/O pin wires.
// Assumes the bench changes its requests just after rising edges of pclk.
`timescale 1ns/1ps

module pmr_far_side (
  input  wire logic        pclk,
  input  wire logic        preset_req,
  input  wire logic [19:0] clk_req,
  input  wire logic        pin_clk_req,
  input  wire logic [9:0]  ext_drive,
  input  wire logic [9:0]  pin_out,
  input  wire logic [9:0]  pin_oe_n,
  output logic             sync_preset,
  output logic      [19:0] clk_term,
  output logic             pin_clk,
  output logic      [9:0]  pin_in
);
  logic [2:0] wait_q;
  logic       hi;

  // Clocks go high only after the preset was seen with clocks low, otherwise it never lands.
  always_ff @(posedge pclk) begin
    wait_q <= !preset_req ? 3'h0 : (hi ? wait_q : wait_q + 3'h1);
  end
  assign hi          = (wait_q == 3'h4);
  assign sync_preset = preset_req;
  assign clk_term    = hi ? 20'hFFFFF : clk_req;
  assign pin_clk     = hi | pin_clk_req;
  // The wire carries the design's value where it drives, the outside value elsewhere.
  assign pin_in      = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule

// ### sim/tb.sv
// Self-checking bench for the macrocell register array: APB access and array-side behaviour.
// Assumes the design files and the far-side model are compiled before it.
`timescale 1ns/1ps
`include "pmr_defs.svh"

module tb;
  typedef struct packed {logic [19:0] s; logic [19:0] ct; logic pc; logic [19:0] fb;} pmr_row_t;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, preset_req = 1'h0, pin_clk_req = 1'h0, sync_preset, pin_clk;
  logic [19:0] sum_term = 20'h0, clk_req = 20'h0, rst_term = 20'h0, clk_term, feedback;
  logic [9:0]  oe_term = 10'h0, ext_drive = 10'h2AA, pin_in, pin_out, pin_oe_n, pin_path;
  int          failures = 0, samples_checked = 0, cycles = 0;
  // TYPE 0xFF000 and CLKSEL 0xF0F0F are set before these rows run.
  pmr_row_t    rows [6] = '{{20'hFFFFF, 20'hFFFFF, 1'h0, 20'h0F0F0}, {20'hFFFFF, 20'h0, 1'h1, 20'hFFFFF},
                            {20'hFFFFF, 20'hFFFFF, 1'h1, 20'h00FFF}, {20'hF0000, 20'hFFFFF, 1'h1, 20'hF0000},
                            {20'h0, 20'hFFFFF, 1'h1, 20'hF0000}, {20'hFFFFF, 20'h0, 1'h0, 20'hF0000}};

  pmr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sum_term(sum_term), .clk_term(clk_term), .rst_term(rst_term), .sync_preset(sync_preset),
    .pin_clk(pin_clk), .oe_term(oe_term), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_path(pin_path), .feedback(feedback));

  pmr_far_side i_far (.pclk(pclk), .preset_req(preset_req), .clk_req(clk_req), .pin_clk_req(pin_clk_req),
    .ext_drive(ext_drive), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .sync_preset(sync_preset),
    .clk_term(clk_term), .pin_clk(pin_clk), .pin_in(pin_in));

  always #25 pclk = ~pclk;

  task automatic complete_run();
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; this only cuts a hang short.
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Data settles before the clocks rise; each clock phase lasts four cycles so the sync sees it.
  task automatic step(logic [19:0] s, logic [19:0] ct, logic pc);
    @(posedge pclk);
    sum_term <= s;
    repeat (3) @(posedge pclk);
    clk_req <= ct;
    pin_clk_req <= pc;
    repeat (4) @(posedge pclk);
    clk_req <= 20'h0;
    pin_clk_req <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h1, `PMR_OFS_TYPE, 32'hFF000);
    apb(1'h1, `PMR_OFS_CLKSEL, 32'hF0F0F);
    apb(1'h0, `PMR_OFS_CLKSEL, 32'h0);
    chk("clksel", 32'hF0F0F, rd);
    foreach (rows[i]) begin
      step(rows[i].s, rows[i].ct, rows[i].pc);
      chk("feedback", {12'h0, rows[i].fb}, {12'h0, feedback});
      for (int p = 0; p < 10; p++)
        chk("pin_out", {31'h0, rows[i].fb[2*p]}, {31'h0, pin_out[p]});
    end
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("feedback_rst", 32'h0, {12'h0, feedback});
    chk("oe_rst", 32'h3FF, {22'h0, pin_oe_n});
    presetn <= 1'h1;
    apb(1'h0, `PMR_OFS_TYPE, 32'h0);
    chk("type_rst", 32'h0, rd);
    @(posedge pclk);
    // With the sum low, only the preset can leave the data registers set.
    sum_term <= 20'h0;
    preset_req <= 1'h1;
    repeat (10) @(posedge pclk);
    preset_req <= 1'h0;
    repeat (6) @(posedge pclk);
    chk("preset", 32'hFFFFF, {12'h0, feedback});
    rst_term <= 20'h00021;
    repeat (5) @(posedge pclk);
    chk("rst_term", 32'hFFFDE, {12'h0, feedback});
    apb(1'h0, `PMR_OFS_STATE, 32'h0);
    chk("state", 32'hFFFDE, rd);
    rst_term <= 20'h0;
    oe_term <= 10'h155;
    repeat (8) @(posedge pclk);
    chk("oe", 32'h2AA, {22'h0, pin_oe_n});
    chk("pin_path", 32'h3FE, {22'h0, pin_path});
    apb(1'h0, `PMR_OFS_PINS, 32'h0);
    chk("pins", 32'h3FE, rd);
    chk("pins_err", 32'h0, {31'h0, err});
    apb(1'h1, `PMR_OFS_SECURE, 32'h1);
    // Writes still land on a secured part; only the verify reads are masked.
    apb(1'h1, `PMR_OFS_TYPE, 32'h12345);
    apb(1'h0, `PMR_OFS_TYPE, 32'h0);
    chk("type_locked", 32'hFFFFF, rd);
    apb(1'h0, `PMR_OFS_CLKSEL, 32'h0);
    chk("clksel_locked", 32'hFFFFF, rd);
    apb(1'h0, `PMR_OFS_SECURE, 32'h0);
    chk("secure_on", 32'h1, rd);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'h1, `PMR_OFS_SECURE, 32'h2);
    apb(1'h0, `PMR_OFS_TYPE, 32'h0);
    chk("type_erased", 32'h0, rd);
    apb(1'h0, `PMR_OFS_SECURE, 32'h0);
    chk("secure_off", 32'h0, rd);
    apb(1'h1, `PMR_OFS_STATE, 32'h0);
    apb(1'h0, `PMR_OFS_STATE, 32'h0);
    chk("state_ro", 32'hFFFDE, rd);
    complete_run();
  end
endmodule
